// ### pkg/crm_consts.svh
// reset values, status word fields, exception vectors and timing counts
// assumes inclusion by bare name from the design file
`ifndef CRM_CONSTS_SVH
`define CRM_CONSTS_SVH
`define CRM_FLAGS_RST 16'h0002
`define CRM_MSW_RST 16'hFFF0
`define CRM_IP_RST 16'hFFF0
`define CRM_CS_RST 16'hF000
`define CRM_SEG_RST 16'h0000
`define CRM_IDT_BASE_RST 24'h000000
`define CRM_IDT_LIMIT_RST 16'h03FF
`define CRM_BOOT_ADDR 24'hFFFFF0
`define CRM_MSW_PE 0
`define CRM_MSW_MP 1
`define CRM_MSW_EM 2
`define CRM_MSW_TS 3
`define CRM_VEC_NO_COPROC 8'h07
`define CRM_VEC_LIMIT 8'h08
`define CRM_VEC_CP_OVERRUN 8'h09
`define CRM_VEC_SEG_OVERRUN 8'h0D
`define CRM_SEG_END 16'hFFFF
`define CRM_SETTLE_CLKS 8'd40
`define CRM_HOLD_GUARD_CLKS 6'd34
`endif

// ### pkg/crm_pkg.sv
// types shared by the reset and mode control block and its users
// assumes the constants header lies on the include path
package crm_pkg;
	// operation classes reported by the instruction decoder
	typedef enum logic [3:0] {
		CRM_OP_NOP = 4'h0,
		CRM_OP_LOAD_STATE_WORD_INSN = 4'h1,
		CRM_OP_STORE_STATE_WORD_INSN = 4'h2,
		CRM_OP_STOP = 4'h3,
		CRM_OP_ESC = 4'h4,
		CRM_OP_WAIT = 4'h5,
		CRM_OP_INT = 4'h6,
		CRM_OP_LIDT = 4'h7,
		CRM_OP_MEM = 4'h8,
		CRM_OP_FETCH = 4'h9
	} crm_op_t;
	// control states, one-hot
	typedef enum logic [2:0] {
		CRM_SETTLE = 3'b001,
		CRM_RUN = 3'b010,
		CRM_HALT = 3'b100
	} crm_fsm_t;
	// one decoded instruction step
	typedef struct packed {
		logic valid;
		crm_op_t op;
		logic [15:0] ip;
		logic [15:0] next_ip;
		logic [15:0] seg;
		logic [15:0] offset;
		logic [23:0] data;
		logic [7:0] vector;
		logic [3:0] len;
		logic word;
		logic exec_past;
		logic stack_multi;
	} crm_req_t;
	// exception, wake and status-word answers
	typedef struct packed {
		logic exc_valid;
		logic [7:0] exc_vec;
		logic restart;
		logic restore;
		logic wake;
		logic [15:0] ret_ip;
		logic store_state_word_insn_valid;
		logic [15:0] store_state_word_insn_data;
	} crm_rsp_t;
	// architectural register values loaded at reset
	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] ip;
		logic [15:0] cs;
		logic [15:0] ds;
		logic [15:0] es;
		logic [15:0] ss;
	} crm_init_t;
	// whole state of the control block
	typedef struct packed {
		crm_fsm_t fsm;
		logic [7:0] cnt;
		logic [5:0] hold_cnt;
		logic hold_ok;
		logic [15:0] machine_state_word;
		logic [23:0] idt_base;
		logic [15:0] idt_limit;
		logic [15:0] halt_ip;
		crm_rsp_t rsp;
		logic run;
		logic bus_ok;
		logic halt_cycle;
		logic first_fetch;
		logic [23:0] fetch_addr;
		logic [19:0] phys;
		logic init_load;
		crm_init_t init;
	} crm_st_t;
endpackage : crm_pkg

// ### rtl/crm_top.sv
// reset sequencing, status word, halt and real-mode address control
// assumes a decoder presenting one step per cycle, synchronous pins
// Operation
// - reset held stops execution and bus cycles
// - after settling, start real mode at FFFFF0
// - reset loads flags, status word, IP, segments
// - status word 16 bits, low four used
// - protection bit sticky, cleared only by reset
// - monitor bit lets wait raise exception 7
// - substitute bit makes coprocessor opcodes raise 7
// - context-changed bit traps next coprocessor use
// - recommended encodings give matching exception 7 triggers
// - load and store of status word work
// - stop insn halts; NMI, enabled irq, reset end
// - wake return address follows the stop insn
// - vector beyond table limit raises exception 8
// - coprocessor operand past FFFF raises interrupt 9
// - word at FFFF or execute past raises 13
// - selector forms 20-bit base, 16-byte aligned
// - segments span 64K, wrap may trap
// - faults restore state except stack push/pop forms
// - reset table base zero, limit 03FF
// - halt entry announced with a halt bus cycle
`timescale 1ns/100ps
`include "crm_consts.svh"

module crm_top (
	input wire logic clk_in, // 25 MHz processor clock
	input wire logic rst_b_in, // synchronous reset, active low
	input wire crm_pkg::crm_req_t req_in, // decoded step
	input wire logic nmi_in, // non-maskable interrupt level
	input wire logic maskable_irq_pin_in, // maskable interrupt level
	input wire logic if_flag_in, // interrupt enable flag
	output logic run_out, // execution allowed
	output logic bus_ok_out, // local bus cycles allowed
	output logic hold_ok_out, // bus grant requests now honoured
	output logic halt_cycle_out, // halt bus cycle pulse
	output logic first_fetch_out, // first fetch pulse
	output logic [23:0] fetch_addr_out, // first fetch address
	output logic [19:0] phys_addr_out, // real-mode physical address
	output logic [15:0] msw_out, // machine_state_word
	output logic init_load_out, // load reset values pulse
	output crm_pkg::crm_init_t init_out, // reset register values
	output crm_pkg::crm_rsp_t rsp_out // exception and answers
);
	import crm_pkg::*;

	crm_st_t q, d;
	logic cp_esc_trap;
	logic cp_wait_trap;
	logic [16:0] esc_end;
	logic [15:0] int_top;
	logic wake;

	// coprocessor trap conditions from the status word
	assign cp_esc_trap = q.machine_state_word[`CRM_MSW_EM] | q.machine_state_word[`CRM_MSW_TS];
	assign cp_wait_trap = q.machine_state_word[`CRM_MSW_MP] & q.machine_state_word[`CRM_MSW_TS];
	// last byte of a coprocessor operand, one bit wider to see overrun
	assign esc_end = {1'b0, req_in.offset} + {13'h0000, req_in.len};
	// highest table byte that a vector touches
	assign int_top = {6'h00, req_in.vector, 2'b11};
	assign wake = nmi_in | (maskable_irq_pin_in & if_flag_in);

	// next-state logic for the whole block
	always_comb begin
		d = q;
		d.rsp.exc_valid = 1'b0;
		d.rsp.wake = 1'b0;
		d.rsp.store_state_word_insn_valid = 1'b0;
		d.halt_cycle = 1'b0;
		d.first_fetch = 1'b0;
		d.init_load = 1'b0;
		// guard window for the external bus requester
		if (q.hold_cnt != `CRM_HOLD_GUARD_CLKS) begin
			d.hold_cnt = q.hold_cnt + 6'd1;
		end
		d.hold_ok = (d.hold_cnt == `CRM_HOLD_GUARD_CLKS);
		unique case (q.fsm)
			CRM_SETTLE: begin
				// quiet interval before the first fetch
				if (q.cnt == `CRM_SETTLE_CLKS - 8'd1) begin
					d.fsm = CRM_RUN;
					d.run = 1'b1;
					d.bus_ok = 1'b1;
					d.first_fetch = 1'b1;
					d.fetch_addr = `CRM_BOOT_ADDR;
				end else begin
					d.cnt = q.cnt + 8'd1;
				end
			end
			CRM_RUN: begin
				if (req_in.valid) begin
					d.rsp.ret_ip = req_in.ip;
					d.rsp.restart = 1'b1;
					// faults leave state as before, bar stack multi-forms
					d.rsp.restore = ~req_in.stack_multi;
					case (req_in.op)
						CRM_OP_LOAD_STATE_WORD_INSN: begin
							// low four bits writable, protection bit sticky
							d.machine_state_word = {q.machine_state_word[15:4], req_in.data[3:0]};
							d.machine_state_word[`CRM_MSW_PE] = q.machine_state_word[`CRM_MSW_PE] |
								req_in.data[`CRM_MSW_PE];
						end
						CRM_OP_STORE_STATE_WORD_INSN: begin
							d.rsp.store_state_word_insn_valid = 1'b1;
							d.rsp.store_state_word_insn_data = q.machine_state_word;
						end
						CRM_OP_STOP: begin
							d.fsm = CRM_HALT;
							d.run = 1'b0;
							d.bus_ok = 1'b0;
							d.halt_cycle = 1'b1;
							d.halt_ip = req_in.next_ip;
						end
						CRM_OP_ESC: begin
							if (cp_esc_trap) begin
								d.rsp.exc_valid = 1'b1;
								d.rsp.exc_vec = `CRM_VEC_NO_COPROC;
							end else if (esc_end > 17'h0FFFF) begin
								d.rsp.exc_valid = 1'b1;
								d.rsp.exc_vec = `CRM_VEC_CP_OVERRUN;
								d.rsp.restart = 1'b0;
								d.rsp.restore = 1'b0;
								d.rsp.ret_ip = req_in.next_ip;
							end
						end
						CRM_OP_WAIT: begin
							if (cp_wait_trap) begin
								d.rsp.exc_valid = 1'b1;
								d.rsp.exc_vec = `CRM_VEC_NO_COPROC;
							end
						end
						CRM_OP_INT: begin
							if (int_top > q.idt_limit) begin
								d.rsp.exc_valid = 1'b1;
								d.rsp.exc_vec = `CRM_VEC_LIMIT;
							end
						end
						CRM_OP_LIDT: begin
							d.idt_base = req_in.data;
							d.idt_limit = req_in.offset;
						end
						CRM_OP_MEM, CRM_OP_FETCH: begin
							// 20-bit real-mode address, wraps at 1M
							d.phys = {req_in.seg, 4'h0} +
								{4'h0, req_in.offset};
							if ((req_in.word &&
								req_in.offset == `CRM_SEG_END) ||
								(req_in.op == CRM_OP_FETCH &&
								req_in.exec_past)) begin
								d.rsp.exc_valid = 1'b1;
								d.rsp.exc_vec = `CRM_VEC_SEG_OVERRUN;
							end
						end
						default: begin
						end
					endcase
				end
			end
			CRM_HALT: begin
				// only interrupts or reset leave the stopped state
				if (wake) begin
					d.fsm = CRM_RUN;
					d.run = 1'b1;
					d.bus_ok = 1'b1;
					d.rsp.wake = 1'b1;
					d.rsp.ret_ip = q.halt_ip;
					d.rsp.restart = 1'b0;
					d.rsp.restore = 1'b0;
				end
			end
		endcase
	end

	// state register; reset forces every field to a constant
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			q.fsm <= CRM_SETTLE;
			q.cnt <= 8'h00;
			q.hold_cnt <= 6'h00;
			q.hold_ok <= 1'b0;
			q.machine_state_word <= `CRM_MSW_RST;
			q.idt_base <= `CRM_IDT_BASE_RST;
			q.idt_limit <= `CRM_IDT_LIMIT_RST;
			q.halt_ip <= 16'h0000;
			q.rsp <= '0;
			q.run <= 1'b0;
			q.bus_ok <= 1'b0;
			q.halt_cycle <= 1'b0;
			q.first_fetch <= 1'b0;
			q.fetch_addr <= `CRM_BOOT_ADDR;
			q.phys <= 20'h00000;
			q.init_load <= 1'b1;
			q.init.flags <= `CRM_FLAGS_RST;
			q.init.ip <= `CRM_IP_RST;
			q.init.cs <= `CRM_CS_RST;
			q.init.ds <= `CRM_SEG_RST;
			q.init.es <= `CRM_SEG_RST;
			q.init.ss <= `CRM_SEG_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign run_out = q.run;
	assign bus_ok_out = q.bus_ok;
	assign hold_ok_out = q.hold_ok;
	assign halt_cycle_out = q.halt_cycle;
	assign first_fetch_out = q.first_fetch;
	assign fetch_addr_out = q.fetch_addr;
	assign phys_addr_out = q.phys;
	assign msw_out = q.machine_state_word;
	assign init_load_out = q.init_load;
	assign init_out = q.init;
	assign rsp_out = q.rsp;

	// cycles since the last reset release, saturating; checker use only
	logic [7:0] chk_rel_q;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			chk_rel_q <= 8'h00;
		end else if (chk_rel_q != 8'hFF) begin
			chk_rel_q <= chk_rel_q + 8'h01;
		end
	end

	// checks on the sequencing and trap logic
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence seq_release;
		!rst_b_in ##1 rst_b_in;
	endsequence

	sequence seq_esc_trapped;
		req_in.valid && req_in.op == CRM_OP_ESC && q.fsm == CRM_RUN &&
			cp_esc_trap;
	endsequence

	sequence seq_esc_overrun;
		req_in.valid && req_in.op == CRM_OP_ESC && q.fsm == CRM_RUN &&
			!cp_esc_trap &&
			17'(req_in.offset) + 17'(req_in.len) > 17'h0FFFF;
	endsequence

	sequence seq_halted_idle;
		q.fsm == CRM_HALT && !nmi_in &&
			!(maskable_irq_pin_in && if_flag_in);
	endsequence

	chk_reset_quiet: assert property (disable iff (1'b0)
		!rst_b_in |=> !q.bus_ok && !q.run)
		else $error("bus or execution active after reset");
	chk_settle_len: assert property (
		q.first_fetch == (chk_rel_q == 8'h28))
		else $error("first fetch not 40 clocks after release");
	chk_first_addr: assert property ($rose(q.first_fetch) |->
		q.fetch_addr == 24'hFFFFF0 && !q.machine_state_word[0] && q.bus_ok)
		else $error("first fetch address or mode wrong");
	chk_pe_sticky: assert property (q.machine_state_word[0] |=> q.machine_state_word[0])
		else $error("protection bit cleared without reset");
	chk_esc_trap: assert property (seq_esc_trapped |=>
		q.rsp.exc_valid && q.rsp.exc_vec == 8'h07 && q.rsp.restart)
		else $error("coprocessor opcode did not raise 7");
	chk_wait_trap: assert property (req_in.valid &&
		req_in.op == CRM_OP_WAIT && q.fsm == CRM_RUN |=>
		q.rsp.exc_valid == $past(q.machine_state_word[1] & q.machine_state_word[3]))
		else $error("wait trap does not follow status word");
	chk_halt_quiet: assert property ($rose(q.halt_cycle) |->
		!q.bus_ok && !q.run ##1 q.fsm == CRM_HALT || q.rsp.wake)
		else $error("halt entry left bus active");
	chk_halt_ret: assert property (q.rsp.wake |->
		q.rsp.ret_ip == q.halt_ip && $past(q.fsm) == CRM_HALT)
		else $error("wake return address wrong");
	chk_int_limit: assert property (req_in.valid &&
		req_in.op == CRM_OP_INT && q.fsm == CRM_RUN &&
		int_top > q.idt_limit |=> q.rsp.exc_vec == 8'h08 &&
		q.rsp.ret_ip == $past(req_in.ip))
		else $error("table limit fault missing");
	chk_word_wrap: assert property (req_in.valid &&
		req_in.op == CRM_OP_MEM && req_in.word &&
		req_in.offset == 16'hFFFF && q.fsm == CRM_RUN |=>
		q.rsp.exc_valid && q.rsp.exc_vec == 8'h0D)
		else $error("word wrap fault missing");
	chk_hold_guard: assert property (
		q.hold_ok == (chk_rel_q >= 8'h22))
		else $error("bus grant allowed before guard ends");
	chk_phys_form: assert property (req_in.valid &&
		req_in.op == CRM_OP_MEM && q.fsm == CRM_RUN |=>
		q.phys == 20'(({4'h0, $past(req_in.seg)} << 4) +
		{4'h0, $past(req_in.offset)}))
		else $error("real-mode address wrong");
	// reset values and the single load pulse after release
	chk_init_drop: assert property (disable iff (1'b0)
		seq_release |-> q.init_load && q.init.cs == 16'hF000 ##1
		!q.init_load)
		else $error("reset register values not offered once");
	chk_reset_table: assert property (disable iff (1'b0)
		!rst_b_in |=> q.idt_base == 24'h000000 &&
		q.idt_limit == 16'h03FF && q.machine_state_word == 16'hFFF0)
		else $error("table or status word not reset");
	chk_settle_quiet: assert property (q.fsm == CRM_SETTLE |->
		!q.bus_ok && !q.run && !q.rsp.exc_valid && !q.rsp.store_state_word_insn_valid)
		else $error("activity during the settling interval");
	// status word shape and read-back
	chk_msw_upper: assert property (q.machine_state_word[15:4] == 12'hFFF)
		else $error("unused status word bits changed");
	chk_store_state_word_insn_read: assert property (req_in.valid &&
		req_in.op == CRM_OP_STORE_STATE_WORD_INSN && q.fsm == CRM_RUN |=>
		q.rsp.store_state_word_insn_valid && q.rsp.store_state_word_insn_data == $past(q.machine_state_word))
		else $error("status word read wrong");
	// coprocessor operand overrun at the segment end
	chk_esc_overrun: assert property (seq_esc_overrun |=>
		q.rsp.exc_valid && q.rsp.exc_vec == 8'h09 && !q.rsp.restart &&
		q.rsp.ret_ip == $past(req_in.next_ip))
		else $error("coprocessor operand overrun not raised");
	chk_esc_fits: assert property (req_in.valid &&
		req_in.op == CRM_OP_ESC && q.fsm == CRM_RUN && !cp_esc_trap &&
		17'(req_in.offset) + 17'(req_in.len) <= 17'h0FFFF |=>
		!q.rsp.exc_valid)
		else $error("coprocessor operand trapped without overrun");
	// halt holds until an enabled interrupt arrives
	chk_halt_stays: assert property (seq_halted_idle |=>
		q.fsm == CRM_HALT && !q.run && !q.bus_ok && !q.rsp.exc_valid)
		else $error("halt left without an enabled interrupt");
	chk_wake_exit: assert property (q.fsm == CRM_HALT &&
		(nmi_in || maskable_irq_pin_in && if_flag_in) |=>
		q.rsp.wake && q.run && q.bus_ok && q.fsm == CRM_RUN)
		else $error("enabled interrupt did not end halt");
	// table load, execute overrun and restore rule
	chk_lidt_load: assert property (req_in.valid &&
		req_in.op == CRM_OP_LIDT && q.fsm == CRM_RUN |=>
		q.idt_base == $past(req_in.data) &&
		q.idt_limit == $past(req_in.offset))
		else $error("interrupt table load wrong");
	chk_fetch_past: assert property (req_in.valid &&
		req_in.op == CRM_OP_FETCH && req_in.exec_past &&
		q.fsm == CRM_RUN |=> q.rsp.exc_valid &&
		q.rsp.exc_vec == 8'h0D && q.rsp.restart)
		else $error("execute past segment end not raised");
	chk_restore_form: assert property (req_in.valid &&
		req_in.op == CRM_OP_MEM && req_in.word &&
		req_in.offset == 16'hFFFF && q.fsm == CRM_RUN |=>
		q.rsp.restore == !$past(req_in.stack_multi))
		else $error("state restore flag wrong");
endmodule : crm_top

// ### testbench/crm_far_model.sv
// far side: interrupt sources and the external bus requester
// assumes the bench raises its commands just after a falling edge
`timescale 1ns/100ps

module crm_far_model (
	input wire logic hold_ok_in, // grant window open
	input wire logic nmi_cmd_in, // bench asks for nmi
	input wire logic irq_cmd_in, // bench asks for a maskable request
	output logic nmi_out, // nmi level
	output logic irq_out, // maskable request level
	output logic hold_req_out // bus grant request
);
	// interrupt levels follow the bench's commands
	assign nmi_out = nmi_cmd_in;
	assign irq_out = irq_cmd_in;
	// requester stays quiet until the guard interval after reset ends
	assign hold_req_out = hold_ok_in;
endmodule : crm_far_model

// ### testbench/test_cpu_reset_mode_control.sv
// bench for the reset, status word, halt and real-mode address block
// assumes the design package and the far-side model are compiled first
`timescale 1ns/100ps

module test_cpu_reset_mode_control;
	import crm_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic if_flag_in = 1'b0;
	logic nmi_cmd = 1'b0;
	logic irq_cmd = 1'b0;
	logic nmi, irq, hold_req, run, bus_ok, hold_ok, halt_cyc, first, ld;
	crm_req_t req_in = '0;
	logic [23:0] fetch;
	logic [19:0] phys;
	logic [15:0] machine_state_word;
	crm_init_t init;
	crm_rsp_t rsp;
	int errors = 0;
	int comparisons = 0;

	crm_far_model u_far (.hold_ok_in(hold_ok), .nmi_cmd_in(nmi_cmd),
		.irq_cmd_in(irq_cmd), .nmi_out(nmi), .irq_out(irq),
		.hold_req_out(hold_req));
	crm_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req_in),
		.nmi_in(nmi), .maskable_irq_pin_in(irq), .if_flag_in(if_flag_in),
		.run_out(run), .bus_ok_out(bus_ok), .hold_ok_out(hold_ok),
		.halt_cycle_out(halt_cyc), .first_fetch_out(first),
		.fetch_addr_out(fetch), .phys_addr_out(phys), .msw_out(machine_state_word),
		.init_load_out(ld), .init_out(init), .rsp_out(rsp));

	// 25 MHz clock
	initial begin
		forever #20 clk_in = ~clk_in;
	end

	// compare and count
	task automatic chk(input string n, input logic [95:0] e,
		input logic [95:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// one decoded step, left at the falling edge of the answer cycle
	task automatic go(input crm_op_t op, input logic [15:0] sg,
		input logic [15:0] of, input logic [23:0] d, input logic [7:0] v,
		input logic [3:0] ln, input logic [2:0] f);
		@(negedge clk_in);
		req_in = '{1'b1, op, 16'h0100, 16'h0103, sg, of, d, v, ln, f[2],
			f[1], f[0]};
		@(negedge clk_in);
		req_in.valid = 1'b0;
	endtask : go

	// exception answer of the last step
	task automatic ex(input logic v, input logic [7:0] vec, input logic rs,
		input logic [15:0] rip);
		chk("exc_valid", v, rsp.exc_valid);
		if (v) begin
			chk("exc_vec", vec, rsp.exc_vec);
			chk("restart", rs, rsp.restart);
			chk("ret_ip", rip, rsp.ret_ip);
		end
	endtask : ex

	// reset values, settling count and requester guard
	task automatic t_reset();
		int h;
		int f;
		h = 0;
		f = 0;
		rst_b_in = 1'b0;
		repeat (8) @(negedge clk_in);
		chk("run_bus", 2'b00, {run, bus_ok});
		chk("msw", 16'hFFF0, machine_state_word);
		chk("init", {16'h0002, 16'hFFF0, 16'hF000, 48'h0}, init);
		chk("init_load", 1'b1, ld);
		rst_b_in = 1'b1;
		for (int i = 1; i <= 60 && f == 0; i++) begin
			@(negedge clk_in);
			if (hold_ok && h == 0) h = i;
			if (first) f = i;
		end
		chk("hold_guard", 34, h);
		chk("hold_req", 1'b1, hold_req);
		chk("settle", 40, f);
		chk("fetch", 24'hFFFFF0, fetch);
		if (f == 0) stop_test();
	endtask : t_reset

	// every recommended coprocessor encoding with escape and wait
	task automatic t_cop();
		logic [2:0] enc [5] = '{3'b000, 3'b001, 3'b101, 3'b010, 3'b110};
		logic [3:0] w;
		foreach (enc[i]) begin
			w = {enc[i][2], enc[i][0], enc[i][1], 1'b0};
			go(CRM_OP_LOAD_STATE_WORD_INSN, '0, '0, {20'h0, w}, '0, '0, '0);
			go(CRM_OP_STORE_STATE_WORD_INSN, '0, '0, '0, '0, '0, '0);
			chk("store_state_word_insn", {1'b1, 12'hFFF, w}, {rsp.store_state_word_insn_valid, rsp.store_state_word_insn_data});
			go(CRM_OP_ESC, '0, 16'h0010, '0, '0, '0, '0);
			ex(enc[i][0] | enc[i][2], 8'h07, 1'b1, 16'h0100);
			go(CRM_OP_WAIT, '0, '0, '0, '0, '0, '0);
			ex(enc[i][1] & enc[i][2], 8'h07, 1'b1, 16'h0100);
		end
	endtask : t_cop

	// address formation and addressing exceptions
	task automatic t_addr();
		go(CRM_OP_LOAD_STATE_WORD_INSN, '0, '0, '0, '0, '0, '0);
		go(CRM_OP_MEM, 16'h1234, 16'hFFFE, '0, '0, '0, 3'b100);
		chk("phys", 20'h2233E, phys);
		ex(1'b0, '0, '0, '0);
		go(CRM_OP_MEM, 16'hFFFF, 16'h0020, '0, '0, '0, '0);
		chk("phys_wrap", 20'h00010, phys);
		go(CRM_OP_MEM, '0, 16'hFFFF, '0, '0, '0, 3'b100);
		ex(1'b1, 8'h0D, 1'b1, 16'h0100);
		chk("restore", 1'b1, rsp.restore);
		go(CRM_OP_MEM, '0, 16'hFFFF, '0, '0, '0, 3'b101);
		chk("restore_stack", 1'b0, rsp.restore);
		go(CRM_OP_FETCH, '0, '0, '0, '0, '0, 3'b010);
		ex(1'b1, 8'h0D, 1'b1, 16'h0100);
		go(CRM_OP_ESC, '0, 16'hFFFE, '0, '0, 4'h3, '0);
		ex(1'b1, 8'h09, 1'b0, 16'h0103);
		go(CRM_OP_ESC, '0, 16'hFFFF, '0, '0, 4'h1, '0);
		ex(1'b1, 8'h09, 1'b0, 16'h0103);
		go(CRM_OP_ESC, '0, 16'hFFFE, '0, '0, 4'h1, '0);
		ex(1'b0, '0, '0, '0);
		go(CRM_OP_INT, '0, '0, '0, 8'hFF, '0, '0);
		ex(1'b0, '0, '0, '0);
		go(CRM_OP_LIDT, '0, 16'h00FF, '0, '0, '0, '0);
		go(CRM_OP_INT, '0, '0, '0, 8'h3F, '0, '0);
		ex(1'b0, '0, '0, '0);
		go(CRM_OP_INT, '0, '0, '0, 8'h40, '0, '0);
		ex(1'b1, 8'h08, 1'b1, 16'h0100);
	endtask : t_addr

	// halt entry, ignored work while halted, and the nmi and enabled irq ways out
	task automatic t_halt();
		go(CRM_OP_STOP, '0, '0, '0, '0, '0, '0);
		chk("halt", 3'b100, {halt_cyc, run, bus_ok});
		irq_cmd = 1'b1;
		go(CRM_OP_MEM, '0, 16'hFFFF, '0, '0, '0, 3'b100);
		chk("halted", 3'b000, {halt_cyc, rsp.exc_valid, run});
		nmi_cmd = 1'b1;
		@(negedge clk_in);
		nmi_cmd = 1'b0;
		irq_cmd = 1'b0;
		chk("wake", 3'b111, {rsp.wake, run, bus_ok});
		chk("wake_ip", 16'h0103, rsp.ret_ip);
		go(CRM_OP_STOP, '0, '0, '0, '0, '0, '0);
		if_flag_in = 1'b1;
		irq_cmd = 1'b1;
		@(negedge clk_in);
		irq_cmd = 1'b0;
		if_flag_in = 1'b0;
		chk("irq_wake", 2'b11, {rsp.wake, run});
	endtask : t_halt

	// protection bit sticks until a reset in mid-run
	task automatic t_pe();
		go(CRM_OP_LOAD_STATE_WORD_INSN, '0, '0, 24'h1, '0, '0, '0);
		go(CRM_OP_LOAD_STATE_WORD_INSN, '0, '0, '0, '0, '0, '0);
		go(CRM_OP_STORE_STATE_WORD_INSN, '0, '0, '0, '0, '0, '0);
		chk("pe_sticky", 16'hFFF1, rsp.store_state_word_insn_data);
		t_reset();
	endtask : t_pe

	// main sequence
	initial begin
		t_reset();
		t_cop();
		t_addr();
		t_halt();
		t_pe();
		stop_test();
	end
endmodule : test_cpu_reset_mode_control
